/* verilog/sfp_consts.vh */
`ifndef SFP_CONSTS_VH
`define SFP_CONSTS_VH

// Register offsets on the 4-bit register address.
`define SFP_OFS_DATA     4'h0
`define SFP_OFS_IER      4'h1
`define SFP_OFS_IIR      4'h2
`define SFP_OFS_LCR      4'h3
`define SFP_OFS_LSR      4'h5
`define SFP_OFS_CTL      4'h8

// Field positions.
`define SFP_LCR_DIVISOR_ACCESS_SELECT     7
`define SFP_LCR_EPS      4
`define SFP_LCR_PEN      3
`define SFP_LCR_STOP     2
`define SFP_FCR_FIFO_ENABLE_STATE    0
`define SFP_FCR_RXCLR    1
`define SFP_FCR_TXCLR    2
`define SFP_IER_RDA      0
`define SFP_IER_THRE     1
`define SFP_IER_RLS      2

// Reset values and control write mask.
`define SFP_RST_DIV      8'h00
`define SFP_RST_IER      8'h00
`define SFP_RST_LCR      8'h03
`define SFP_RST_CTL      8'h00
`define SFP_CTL_MASK     8'hCC

// Interrupt source codes.
`define SFP_ID_MODEM     3'h0
`define SFP_ID_THRE      3'h1
`define SFP_ID_RDA       3'h2
`define SFP_ID_RLS       3'h3
`define SFP_ID_TIMEOUT   3'h6

// Timing counts and FIFO sizes.
`define SFP_SYS_DIV      5'h0B
`define SFP_HOST_DIV     5'h12
`define SFP_OVERSAMPLE   4'hF
`define SFP_START_MID    4'h7
`define SFP_FIFO_DEPTH   16
`define SFP_FIFO_AW      4

`endif

/* verilog/sfp_top.v */
`timescale 1ns/1ns
`include "sfp_consts.vh"
// What this block does
// - Bit rate is source clock over 16 times divisor.
// - Divisor bytes plus clock source select set rate.
// - Source 01 system/11, 00 host clock/18.
// - Frame: low start, LSB data, parity, high stop.
// - Idle serial line stays high.
// - Falling edge on input starts frame reception.
// - Transmitter and receiver run independently, full duplex.
// - Sixteen-entry FIFO on each direction.
// - Four idle character times raise character timeout.
// - Source codes 0,1,2,3,6 as defined.
// - Identification reports highest-priority pending source, in the order 3, 2, 6, 1.
// - Identification holds interrupt pending flag.
// - Identification shows FIFO enable state.
// - Receive trigger level selectable, including fourteen.
// - Processor and host bus both reach registers.
// - Access select redirects shared offsets to divisor.
// - Divisor 1 to 65535; zero stops divider.
// - FIFO clear bits flush contents, self-clearing.

// Synchronous FIFO with flush; the array lives here.
module sfp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // Storage words.
  reg [AW-1:0]    wr_ptr_reg;          // Next slot to fill.
  reg [AW-1:0]    rd_ptr_reg;          // Oldest word.
  reg [AW:0]      count_reg;           // Words held.
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign level     = count_reg;

  // Memory write; flush leaves stale words, which the pointers hide.
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap by width since the depth is a power of two.
  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sfp_fifo

module sfp_top (
  // Clock and reset.
  input  wire       CLK_IN,
  input  wire       RST_IN,
  // Processor register port.
  input  wire [3:0] CPU_ADDR_IN,
  input  wire [7:0] CPU_WDATA_IN,
  input  wire       CPU_WR_IN,
  input  wire       CPU_RD_IN,
  // Host bus register port.
  input  wire [3:0] HOST_ADDR_IN,
  input  wire [7:0] HOST_WDATA_IN,
  input  wire       HOST_WR_IN,
  input  wire       HOST_RD_IN,
  output wire       HOST_GRANT_OUT,
  input  wire       HOST_CLK_IN,
  // Shared read data and status.
  output wire [7:0] RDATA_OUT,
  output wire       TX_ROOM_OUT,
  output wire       IRQ_OUT,
  // Serial line.
  input  wire       RXD_IN,
  output wire       TXD_OUT
);
  localparam S_IDLE  = 3'h0; // Line idle.
  localparam S_START = 3'h1; // Start bit.
  localparam S_DATA  = 3'h2; // Data bits.
  localparam S_PAR   = 3'h3; // Parity bit.
  localparam S_STOP  = 3'h4; // Stop bit(s).

  // Trigger level decode for the receive data interrupt.
  function [4:0] sfp_trig;
    input [1:0] sel;
    input       en;
    begin
      if (!en) begin
        sfp_trig = 5'h01;
      end else begin
        case (sel)
          2'h0:    sfp_trig = 5'h01;
          2'h1:    sfp_trig = 5'h04;
          2'h2:    sfp_trig = 5'h08;
          default: sfp_trig = 5'h0E;
        endcase
      end
    end
  endfunction

  // Offset match, used by every register strobe.
  function sfp_hit;
    input [3:0] a;
    input [3:0] o;
    begin
      sfp_hit = (a == o);
    end
  endfunction

  reg  [7:0] dll_reg;       // divisor_low.
  reg  [7:0] dlh_reg;       // divisor_high.
  reg  [7:0] ier_reg;       // interrupt_enable_register.
  reg  [7:0] lcr_reg;       // Line control with divisor_access_select.
  reg  [7:0] ctl_reg;       // serial_port_control, clock source 3:2.
  reg        fifo_enable_state_reg;     // FIFO enable.
  reg  [1:0] trig_reg;      // Receive trigger select.
  reg  [7:0] rdata_reg;     // Registered read answer.
  reg        irq_reg;       // Interrupt output.
  reg        oe_reg;        // Overrun, cleared by status read.
  reg        ls_reg;        // Line status event pending.
  reg        thre_reg;      // Transmit holding empty event.
  reg        txe_prev_reg;  // Transmit FIFO empty last cycle.
  reg  [2:0] hclk_sync_reg; // Host clock synchroniser and history.
  reg  [2:0] rxd_sync_reg;  // Receive pin synchroniser and history.
  reg  [4:0] src_cnt_reg;   // Source prescaler.
  reg  [15:0] div_cnt_reg;  // Baud divider.
  reg  [9:0] to_cnt_reg;    // Timeout tick counter.
  reg  [2:0] tx_st_reg;
  reg  [3:0] tx_tick_reg;
  reg  [2:0] tx_bit_reg;
  reg  [7:0] tx_shift_reg;
  reg        tx_par_reg;
  reg        tx_stop2_reg;
  reg        txd_reg;
  reg  [2:0] rx_st_reg;
  reg  [3:0] rx_tick_reg;
  reg  [2:0] rx_bit_reg;
  reg  [7:0] rx_shift_reg;
  reg        rx_par_reg;
  reg        rx_push_reg;
  reg  [9:0] rx_word_reg;   // {frame error, parity error, data}.

  wire       cpu_act;
  wire [3:0] a;
  wire [7:0] wd;
  wire       wr;
  wire       rd;
  wire       divisor_access_select;
  wire [15:0] divisor;
  wire       host_sel;
  wire       src_step;
  wire       src_en;
  wire       tick;
  wire       wr_thr;
  wire       wr_fcr;
  wire       rd_rbr;
  wire       rd_iir;
  wire       rd_lsr;
  wire       txf_valid;
  wire [7:0] txf_data;
  wire       txf_pop;
  wire       rxf_valid;
  wire       rxf_room;
  wire [9:0] rxf_data;
  wire [4:0] rxf_level;
  wire [2:0] last_bit;
  wire [3:0] frame_bits;
  wire [9:0] to_limit;
  wire       timeout;
  wire       rx_trig;
  reg  [2:0] int_code;
  reg        int_pend;

  // Processor wins a clash; the host is told through its grant.
  assign cpu_act        = CPU_WR_IN | CPU_RD_IN;
  assign HOST_GRANT_OUT = ~cpu_act;
  assign a  = cpu_act ? CPU_ADDR_IN  : HOST_ADDR_IN;
  assign wd = cpu_act ? CPU_WDATA_IN : HOST_WDATA_IN;
  assign wr = cpu_act ? CPU_WR_IN    : HOST_WR_IN;
  assign rd = cpu_act ? CPU_RD_IN    : HOST_RD_IN;

  // Shared offsets follow the access select bit.
  assign divisor_access_select   = lcr_reg[`SFP_LCR_DIVISOR_ACCESS_SELECT];
  assign wr_thr = wr & sfp_hit(a, `SFP_OFS_DATA) & ~divisor_access_select;
  assign wr_fcr = wr & sfp_hit(a, `SFP_OFS_IIR);
  assign rd_rbr = rd & sfp_hit(a, `SFP_OFS_DATA) & ~divisor_access_select;
  assign rd_iir = rd & sfp_hit(a, `SFP_OFS_IIR);
  assign rd_lsr = rd & sfp_hit(a, `SFP_OFS_LSR);

  // Register writes; FIFO clear bits are never stored.
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      dll_reg   <= `SFP_RST_DIV;
      dlh_reg   <= `SFP_RST_DIV;
      ier_reg   <= `SFP_RST_IER;
      lcr_reg   <= `SFP_RST_LCR;
      ctl_reg   <= `SFP_RST_CTL;
      fifo_enable_state_reg <= 1'b0;
      trig_reg  <= 2'h0;
    end else if (wr) begin
      if (sfp_hit(a, `SFP_OFS_DATA) && divisor_access_select) begin
        dll_reg <= wd;
      end
      if (sfp_hit(a, `SFP_OFS_IER)) begin
        if (divisor_access_select) begin
          dlh_reg <= wd;
        end else begin
          ier_reg <= wd & 8'h0F;
        end
      end
      if (wr_fcr) begin
        fifo_enable_state_reg <= wd[`SFP_FCR_FIFO_ENABLE_STATE];
        trig_reg  <= wd[7:6];
      end
      if (sfp_hit(a, `SFP_OFS_LCR)) begin
        lcr_reg <= wd;
      end
      if (sfp_hit(a, `SFP_OFS_CTL)) begin
        ctl_reg <= wd & `SFP_CTL_MASK;
      end
    end
  end

  // Host clock is a pin: two flops, then edge detect on the second.
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      hclk_sync_reg <= 3'h0;
      rxd_sync_reg  <= 3'h7;
    end else begin
      hclk_sync_reg <= {hclk_sync_reg[1:0], HOST_CLK_IN};
      rxd_sync_reg  <= {rxd_sync_reg[1:0], RXD_IN};
    end
  end

  // Source prescaler: host clock over 18 or system clock over 11.
  assign host_sel = (ctl_reg[3:2] == 2'h0);
  assign src_step = host_sel ? (hclk_sync_reg[1] & ~hclk_sync_reg[2])
                             : 1'b1;
  assign src_en   = src_step & (src_cnt_reg == (host_sel ?
                    (`SFP_HOST_DIV - 5'h01) : (`SFP_SYS_DIV - 5'h01)));
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      src_cnt_reg <= 5'h00;
    end else if (src_en) begin
      src_cnt_reg <= 5'h00;
    end else if (src_step) begin
      src_cnt_reg <= src_cnt_reg + 5'h01;
    end
  end

  // Baud divider gives one oversample tick per divisor source pulses.
  assign divisor = {dlh_reg, dll_reg};
  assign tick = src_en & (divisor != 16'h0000) &
                (div_cnt_reg == divisor - 16'h0001);
  always @(posedge CLK_IN) begin
    if (RST_IN || divisor == 16'h0000) begin
      div_cnt_reg <= 16'h0000;
    end else if (tick) begin
      div_cnt_reg <= 16'h0000;
    end else if (src_en) begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // Transmit FIFO is filled by data writes; full drops the write.
  sfp_fifo #(.WIDTH(8), .DEPTH(`SFP_FIFO_DEPTH), .AW(`SFP_FIFO_AW)) u_txf (
    .clk       (CLK_IN),
    .rst       (RST_IN),
    .flush     (wr_fcr & wd[`SFP_FCR_TXCLR]),
    .in_valid  (wr_thr),
    .in_ready  (TX_ROOM_OUT),
    .in_data   (wd),
    .out_valid (txf_valid),
    .out_ready (txf_pop),
    .out_data  (txf_data),
    .level     ()
  );

  // A word is taken only when idle and the divider runs.
  assign txf_pop  = (tx_st_reg == S_IDLE) & (divisor != 16'h0000);
  assign last_bit = {1'b1, lcr_reg[1:0]};

  // Transmitter; the bit period is sixteen oversample ticks.
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      tx_st_reg    <= S_IDLE;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg   <= 1'b0;
      tx_stop2_reg <= 1'b0;
      txd_reg      <= 1'b1;
    end else begin
      case (tx_st_reg)
        S_IDLE: begin
          txd_reg <= 1'b1;
          if (txf_pop && txf_valid) begin
            tx_shift_reg <= txf_data;
            tx_par_reg   <= ~lcr_reg[`SFP_LCR_EPS];
            tx_tick_reg  <= 4'h0;
            tx_bit_reg   <= 3'h0;
            txd_reg      <= 1'b0;
            tx_st_reg    <= S_START;
          end
        end
        default: begin
          if (tick) begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
          end
          // Each branch below acts at the end of a bit period; the stop branch holds one more period for two stop bits.
          if (tick && tx_tick_reg == `SFP_OVERSAMPLE) begin
            case (tx_st_reg)
              S_START, S_DATA: begin
                if (tx_st_reg == S_DATA && tx_bit_reg == last_bit) begin
                  if (lcr_reg[`SFP_LCR_PEN]) begin
                    txd_reg   <= tx_par_reg;
                    tx_st_reg <= S_PAR;
                  end else begin
                    txd_reg      <= 1'b1;
                    tx_stop2_reg <= lcr_reg[`SFP_LCR_STOP];
                    tx_st_reg    <= S_STOP;
                  end
                end else begin
                  // Data leaves least significant bit first.
                  txd_reg      <= tx_shift_reg[0];
                  tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                  if (tx_st_reg == S_DATA) begin
                    tx_bit_reg <= tx_bit_reg + 3'h1;
                  end
                  tx_st_reg <= S_DATA;
                end
              end
              S_PAR: begin
                txd_reg      <= 1'b1;
                tx_stop2_reg <= lcr_reg[`SFP_LCR_STOP];
                tx_st_reg    <= S_STOP;
              end
              default: begin
                tx_stop2_reg <= 1'b0;
                if (!tx_stop2_reg) begin
                  tx_st_reg <= S_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // Receiver runs alone on its own state, so both directions overlap.
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      rx_st_reg    <= S_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg   <= 1'b0;
      rx_push_reg  <= 1'b0;
      rx_word_reg  <= 10'h000;
    end else begin
      rx_push_reg <= 1'b0;
      case (rx_st_reg)
        S_IDLE: begin
          if (!rxd_sync_reg[1] && rxd_sync_reg[2]) begin
            rx_tick_reg <= 4'h0;
            rx_st_reg   <= S_START;
          end
        end
        S_START: begin
          // Start is confirmed at mid-bit, which filters short glitches.
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == `SFP_START_MID) begin
              rx_tick_reg <= 4'h0;
              rx_bit_reg  <= 3'h0;
              rx_par_reg  <= ~lcr_reg[`SFP_LCR_EPS];
              rx_st_reg   <= rxd_sync_reg[1] ? S_IDLE : S_DATA;
            end
          end
        end
        default: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
          end
          if (tick && rx_tick_reg == `SFP_OVERSAMPLE) begin
            case (rx_st_reg)
              S_DATA: begin
                rx_shift_reg <= {rxd_sync_reg[1], rx_shift_reg[7:1]};
                rx_par_reg   <= rx_par_reg ^ rxd_sync_reg[1];
                rx_bit_reg   <= rx_bit_reg + 3'h1;
                if (rx_bit_reg == last_bit) begin
                  rx_st_reg <= lcr_reg[`SFP_LCR_PEN] ? S_PAR : S_STOP;
                end
              end
              S_PAR: begin
                rx_par_reg <= rx_par_reg ^ rxd_sync_reg[1];
                rx_st_reg  <= S_STOP;
              end
              default: begin
                // Only the first stop bit is checked.
                rx_word_reg <= {~rxd_sync_reg[1], rx_par_reg &
                                lcr_reg[`SFP_LCR_PEN],
                                rx_shift_reg >> (2'h3 - lcr_reg[1:0])};
                rx_push_reg <= 1'b1;
                rx_st_reg   <= S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Receive FIFO carries the error bits beside each character.
  sfp_fifo #(.WIDTH(10), .DEPTH(`SFP_FIFO_DEPTH), .AW(`SFP_FIFO_AW)) u_rxf (
    .clk       (CLK_IN),
    .rst       (RST_IN),
    .flush     (wr_fcr & wd[`SFP_FCR_RXCLR]),
    .in_valid  (rx_push_reg),
    .in_ready  (rxf_room),
    .in_data   (rx_word_reg),
    .out_valid (rxf_valid),
    .out_ready (rd_rbr),
    .out_data  (rxf_data),
    .level     (rxf_level)
  );

  // Four character times are frame bits times sixty-four ticks.
  assign frame_bits = 4'h7 + {2'h0, lcr_reg[1:0]} +
                      {3'h0, lcr_reg[`SFP_LCR_PEN]} +
                      {3'h0, lcr_reg[`SFP_LCR_STOP]};
  assign to_limit   = {frame_bits, 6'h00};
  assign timeout    = rxf_valid & (to_cnt_reg == to_limit);
  assign rx_trig    = (rxf_level >= sfp_trig(trig_reg, fifo_enable_state_reg));
  always @(posedge CLK_IN) begin
    if (RST_IN || rx_push_reg || rd_rbr || !rxf_valid) begin
      to_cnt_reg <= 10'h000;
    end else if (tick && to_cnt_reg != to_limit) begin
      to_cnt_reg <= to_cnt_reg + 10'h001;
    end
  end

  // Event flags; in each, a new event wins over a clearing access.
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      oe_reg       <= 1'b0;
      ls_reg       <= 1'b0;
      thre_reg     <= 1'b0;
      txe_prev_reg <= 1'b1;
    end else begin
      txe_prev_reg <= ~txf_valid;
      if (rx_push_reg && !rxf_room) begin
        oe_reg <= 1'b1;
      end else if (rd_lsr) begin
        oe_reg <= 1'b0;
      end
      if (rx_push_reg && (!rxf_room || rx_word_reg[9:8] != 2'h0)) begin
        ls_reg <= 1'b1;
      end else if (rd_lsr) begin
        ls_reg <= 1'b0;
      end
      if (!txf_valid && !txe_prev_reg) begin
        thre_reg <= 1'b1;
      end else if (wr_thr || (rd_iir && int_code == `SFP_ID_THRE)) begin
        thre_reg <= 1'b0;
      end
    end
  end

  // Priority encoder; no modem source exists, so code 0 never wins.
  always @* begin
    int_pend = 1'b1;
    int_code = `SFP_ID_MODEM;
    if (ier_reg[`SFP_IER_RLS] && ls_reg) begin
      int_code = `SFP_ID_RLS;
    end else if (ier_reg[`SFP_IER_RDA] && rx_trig) begin
      int_code = `SFP_ID_RDA;
    end else if (ier_reg[`SFP_IER_RDA] && timeout) begin
      int_code = `SFP_ID_TIMEOUT;
    end else if (ier_reg[`SFP_IER_THRE] && thre_reg) begin
      int_code = `SFP_ID_THRE;
    end else begin
      int_pend = 1'b0;
    end
  end

  // Read answer registered one cycle after the strobe.
  always @(posedge CLK_IN) begin
    if (RST_IN) begin
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      irq_reg <= int_pend;
      if (rd) begin
        case (a)
          `SFP_OFS_DATA: rdata_reg <= divisor_access_select ? dll_reg : rxf_data[7:0];
          `SFP_OFS_IER:  rdata_reg <= divisor_access_select ? dlh_reg : ier_reg;
          `SFP_OFS_IIR:  rdata_reg <= {fifo_enable_state_reg, fifo_enable_state_reg, 2'h0,
                                       int_code, ~int_pend};
          `SFP_OFS_LCR:  rdata_reg <= lcr_reg;
          `SFP_OFS_LSR:  rdata_reg <= {1'b0, ~txf_valid &
                                       (tx_st_reg == S_IDLE), ~txf_valid,
                                       1'b0, rxf_data[9] & rxf_valid,
                                       rxf_data[8] & rxf_valid, oe_reg,
                                       rxf_valid};
          `SFP_OFS_CTL:  rdata_reg <= ctl_reg;
          default:       rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign IRQ_OUT   = irq_reg;
  assign TXD_OUT   = txd_reg;
endmodule // sfp_top

/* sim/sfp_checker.sv */
`timescale 1ns/1ns
// Port-level watch on the serial block; sees only its top-level pins.
module sfp_checker (
  input wire       CLK_IN,
  input wire       RST_IN,
  input wire [3:0] CPU_ADDR_IN,
  input wire [7:0] CPU_WDATA_IN,
  input wire       CPU_WR_IN,
  input wire       CPU_RD_IN,
  input wire [3:0] HOST_ADDR_IN,
  input wire       HOST_RD_IN,
  input wire       HOST_GRANT_OUT,
  input wire [7:0] RDATA_OUT,
  input wire       TX_ROOM_OUT,
  input wire       IRQ_OUT,
  input wire       TXD_OUT
);
  // A start bit may lose up to one tick, so 15 ticks of 11 clocks.
  localparam int MIN_BIT = 165;
  logic [15:0] low_cnt; // Length of the current low run on the line.
  logic        rd_d;    // Some read strobe was seen on the last edge.
  // Count low cycles; the count stays valid on the edge the line rises.
  always @(posedge CLK_IN) begin
    low_cnt <= (RST_IN || TXD_OUT) ? 16'h0000 : low_cnt + 16'h0001;
    rd_d    <= CPU_RD_IN | HOST_RD_IN;
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_low_run; !TXD_OUT [*8]; endsequence
  sequence s_high_run; TXD_OUT [*8]; endsequence
  property p_reset_state;
    disable iff (1'b0) RST_IN |=> TXD_OUT && !IRQ_OUT && TX_ROOM_OUT &&
      RDATA_OUT == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Outputs not at rest after reset.");
  property p_grant;
    HOST_GRANT_OUT == !(CPU_WR_IN || CPU_RD_IN);
  endproperty
  a_grant: assert property (p_grant)
    else $error("Host grant does not follow processor strobes.");
  property p_start_len; $fell(TXD_OUT) |-> s_low_run; endproperty
  a_start_len: assert property (p_start_len)
    else $error("Start bit too short.");
  property p_stop_len; $rose(TXD_OUT) |-> s_high_run; endproperty
  a_stop_len: assert property (p_stop_len)
    else $error("High level on the line too short.");
  property p_bit_len; $rose(TXD_OUT) |-> low_cnt >= MIN_BIT; endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("Low run shorter than one bit time.");
  property p_rdata_stands; !$stable(RDATA_OUT) |-> rd_d; endproperty
  a_rdata_stands: assert property (p_rdata_stands)
    else $error("Read data changed without a read.");
  property p_cpu_unmapped;
    CPU_RD_IN && CPU_ADDR_IN == 4'h4 |=> RDATA_OUT == 8'h00;
  endproperty
  a_cpu_unmapped: assert property (p_cpu_unmapped)
    else $error("Unmapped processor read not zero.");
  property p_host_unmapped;
    HOST_RD_IN && HOST_GRANT_OUT && HOST_ADDR_IN == 4'h4 |=>
      RDATA_OUT == 8'h00;
  endproperty
  a_host_unmapped: assert property (p_host_unmapped)
    else $error("Unmapped host read not zero.");
  property p_tx_clear;
    CPU_WR_IN && CPU_ADDR_IN == 4'h2 && CPU_WDATA_IN[2] |-> ##[1:2]
      TX_ROOM_OUT;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("Transmit FIFO still full after clear.");
endmodule // sfp_checker
bind sfp_top sfp_checker i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .CPU_ADDR_IN(CPU_ADDR_IN), .CPU_WDATA_IN(CPU_WDATA_IN),
  .CPU_WR_IN(CPU_WR_IN), .CPU_RD_IN(CPU_RD_IN), .HOST_ADDR_IN(HOST_ADDR_IN),
  .HOST_RD_IN(HOST_RD_IN), .HOST_GRANT_OUT(HOST_GRANT_OUT),
  .RDATA_OUT(RDATA_OUT), .TX_ROOM_OUT(TX_ROOM_OUT), .IRQ_OUT(IRQ_OUT),
  .TXD_OUT(TXD_OUT));

/* sim/sfp_uart_model.sv */
`timescale 1ns/1ns
// Far-end transceiver, 8 data bits, no parity, one stop bit.
module sfp_uart_model #(parameter int BIT = 176) (
  input  wire  clk,
  input  wire  txd,
  output logic rxd
);
  logic [7:0] got[$]; // Characters taken off the line, oldest first.
  logic [7:0] d;      // Character being assembled.
  int         bad;    // Frames with a wrong start or stop level.
  int         i;      // Bit index of the receiver.
  initial begin
    rxd = 1'b1;
    bad = 0;
  end
  // Sends one character, least significant bit first.
  task automatic send(input logic [7:0] v);
    int k;
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (k = 0; k < 8; k++) begin
      rxd <= v[k];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // Samples each bit at its middle; a wrong edge level is counted.
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    if (txd !== 1'b0) bad++;
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    if (txd !== 1'b1) bad++;
    got.push_back(d);
  end
endmodule // sfp_uart_model

/* sim/sfp_top_tb.sv */
`timescale 1ns/1ns
`include "sfp_consts.vh"
// Self-checking bench for the serial block.
module sfp_top_tb;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
  logic       clk = 1'b0, rst = 1'b1, hclk = 1'b0;
  logic [3:0] ca = 4'h0, ha = 4'h0;
  logic [7:0] cd = 8'h00, hd = 8'h00;
  logic       cw = 1'b0, cr = 1'b0, hw = 1'b0, hr = 1'b0;
  wire  [7:0] rdata;
  wire        grant, room, irq, rxd, txd;
  int         mismatches = 0, compares = 0;
  always #5 clk = ~clk;
  // Host bus clock, one third of the system clock rate, rising edges aligned.
  always #15 hclk = ~hclk;
  sfp_top i_dut (.CLK_IN(clk), .RST_IN(rst), .CPU_ADDR_IN(ca),
    .CPU_WDATA_IN(cd), .CPU_WR_IN(cw), .CPU_RD_IN(cr), .HOST_ADDR_IN(ha),
    .HOST_WDATA_IN(hd), .HOST_WR_IN(hw), .HOST_RD_IN(hr),
    .HOST_GRANT_OUT(grant), .HOST_CLK_IN(hclk), .RDATA_OUT(rdata),
    .TX_ROOM_OUT(room), .IRQ_OUT(irq), .RXD_IN(rxd), .TXD_OUT(txd));
  sfp_uart_model i_far (.clk(clk), .txd(txd), .rxd(rxd));
  // One processor write; an idle edge separates calls.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); #1 ca = a; cd = d; cw = 1'b1;
    @(posedge clk); #1 cw = 1'b0;
  endtask
  // One processor read; the answer lands on the read edge.
  task automatic rd(input logic [3:0] a, input logic [7:0] e, string n);
    @(posedge clk); #1 ca = a; cr = 1'b1;
    @(posedge clk); #1 cr = 0;
    `CHK(n, e, rdata)
  endtask
  // One host access, write when w is set.
  task automatic hacc(input logic w, input logic [3:0] a, logic [7:0] d);
    @(posedge clk); #1 ha = a; hd = d; hw = w; hr = ~w;
    @(posedge clk); #1 hw = 0; hr = 0;
  endtask
  // Reset values, unmapped place, host port and a clash it loses.
  task automatic t_regs;
    rd(`SFP_OFS_LCR, `SFP_RST_LCR, "lcr");
    rd(`SFP_OFS_IIR, 8'h01, "iir");
    rd(`SFP_OFS_CTL, `SFP_RST_CTL, "ctl");
    rd(4'h4, 8'h00, "unmapped");
    @(posedge clk); #1 ha = `SFP_OFS_LCR; hd = 8'h1B; hw = 1; cr = 1;
    @(posedge clk); #1 hw = 0; cr = 0;
    rd(`SFP_OFS_LCR, 8'h03, "lcr clash");
    hacc(1'b1, `SFP_OFS_LCR, 8'h1B);
    hacc(1'b0, `SFP_OFS_LCR, 8'h00);
    `CHK("host lcr", 8'h1B, rdata)
    hacc(1'b0, 4'h4, 8'h00);
    `CHK("host unmapped", 8'h00, rdata)
    hacc(1'b1, `SFP_OFS_LCR, 8'h03);
  endtask
  // Divisor still zero: the FIFO fills, nothing leaves, clear empties it.
  task automatic t_full;
    int i;
    for (i = 0; i < 16; i++) begin
      `CHK("room", 1'b1, room)
      wr(`SFP_OFS_DATA, i[7:0]);
    end
    `CHK("room full", 1'b0, room)
    repeat (400) @(posedge clk);
    #1 `CHK("line idle", 1'b1, txd)
    wr(`SFP_OFS_IIR, 8'h04);
    repeat (2) @(posedge clk);
    #1 `CHK("room cleared", 1'b1, room)
  endtask
  // Divisor 1 from the system clock, FIFOs on, two sources enabled.
  task automatic t_setup;
    wr(`SFP_OFS_LCR, 8'h83);
    wr(`SFP_OFS_DATA, 8'h01);
    wr(`SFP_OFS_IER, 8'h00);
    rd(`SFP_OFS_DATA, 8'h01, "div low");
    wr(`SFP_OFS_LCR, 8'h03);
    wr(`SFP_OFS_IER, 8'h03);
    rd(`SFP_OFS_IER, 8'h03, "ier");
    wr(`SFP_OFS_CTL, 8'h04);
    wr(`SFP_OFS_IIR, 8'h07);
  endtask
  // Back-to-back sends while a character arrives.
  task automatic t_txrx;
    int n;
    `CHK("stale", 0, i_far.got.size())
    fork
      begin
        wr(`SFP_OFS_DATA, 8'h3C);
        wr(`SFP_OFS_DATA, 8'hA5);
        wr(`SFP_OFS_DATA, 8'h81);
      end
      i_far.send(8'h5A);
    join
    for (n = 0; n < 6000 && i_far.got.size() < 3; n++) @(posedge clk);
    `CHK("tx count", 3, i_far.got.size())
    `CHK("tx 0", 8'h3C, i_far.got[0])
    `CHK("tx 1", 8'hA5, i_far.got[1])
    `CHK("tx 2", 8'h81, i_far.got[2])
    `CHK("framing", 0, i_far.bad)
    rd(`SFP_OFS_IIR, 8'hC4, "iir rx");
    rd(`SFP_OFS_DATA, 8'h5A, "rx data");
    rd(`SFP_OFS_IIR, 8'hC2, "iir tx");
    rd(`SFP_OFS_IIR, 8'hC1, "iir none");
  endtask
  // One character under a 14 trigger: only the timeout may report it.
  task automatic t_timeout;
    int n;
    wr(`SFP_OFS_IIR, 8'hC1);
    i_far.send(8'h77);
    rd(`SFP_OFS_IIR, 8'hC1, "iir below trig");
    for (n = 0; n < 9000 && irq !== 1'b1; n++) #10;
    `CHK("timeout time", 1'b1, n > 6850 && n < 7050)
    rd(`SFP_OFS_IIR, 8'hCC, "iir timeout");
    rd(`SFP_OFS_DATA, 8'h77, "rx data 2");
    rd(`SFP_OFS_IIR, 8'hC1, "iir after");
  endtask
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_regs;
    t_full;
    t_setup;
    t_txrx;
    t_timeout;
    @(posedge clk); #1 rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    rd(`SFP_OFS_IIR, 8'h01, "iir again");
    end_sim;
  end
  // The run needs some 15000 cycles; a hang is cut well after that.
  initial begin
    #400000 mismatches++;
    end_sim;
  end
endmodule // sfp_top_tb
